// [src/sbs_serial.sv]
// Serial transceiver: break transmit, break receive and synchronous master
// Summary of operation
// - Break is start bit, twelve zero bits, then stop bit at bit rate.
// - With break request and transmit enabled, data write sends all zeros.
// - Hardware clears break request after its stop bit; queued byte follows.
// - Shift register empty flag tracks break transmission like normal characters.
// - Buffer empty flag rises when data register empties; software waits.
// - Received break gives ready flag, framing error and data 00h.
// - Wake-on-edge watches two transitions, flags, then receives next byte.
// - Synchronous data line is half duplex, never sending and receiving.
// - Synchronous characters carry no start or stop bits.
// - Control bits select synchronous mode, clock master and port enable.
// - Both receive enables clear means transmit direction, else receive.
// - Master drives shift clock and enables clock pin driver.
// - Exactly one clock cycle per data bit, no extras.
// - Clock polarity bit sets idle level and data change edge.
// - Master transmit drives data and clock pins with drivers enabled.
// - Write waits while shift register busy, else loads and starts.
// - Data changes on leading clock edge, stable until next leading.
// - Nine-bit mode sends ninth bit, loaded before the low byte.
// - Transmit shift register has no software address.
// - Wake mode clears its enable on rising line and returns idle.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sbs_serial (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        data_pin_i,
  output logic             data_pin_o,
  output logic             data_pin_oe_o,
  output logic             clock_pin_o,
  output logic             clock_pin_oe_o
);

  typedef struct packed {
    logic                clk_pol;
    logic                wide_div;
    logic                wake_en;
    logic                autobaud;
    logic                port_en;
    logic                nine_rx;
    logic                single_rx;
    logic                cont_rx;
    logic                frame_err;
    logic                ninth_rx;
    logic [7:0]          div_low;
    logic [7:0]          div_high;
    logic                master;
    logic                nine_tx;
    logic                tx_en;
    logic                sync_mode;
    logic                break_req;
    logic                high_spd;
    logic                ninth_tx;
    logic [8:0]          tx_buf;
    logic                tx_full;
    logic [11:0]         tx_shift;
    logic [3:0]          tx_bits;
    logic                tx_brk;
    sbs_pkg::sbs_tx_e    tx_state;
    logic [23:0]         tx_cnt;
    sbs_pkg::sbs_rx_e    rx_state;
    logic [23:0]         rx_cnt;
    logic [8:0]          rx_shift;
    logic [3:0]          rx_bits;
    logic [7:0]          rx_data;
    logic                rx_ready;
    logic                line_meta;
    logic                line_sync;
    logic                line_prev;
    sbs_pkg::sbs_pins_s  pins;
    logic [31:0]         rdata;
    logic                slverr;
  } sbs_state_s;

  sbs_state_s           st;
  sbs_state_s           next_st;
  sbs_pkg::sbs_apb_req_s req;
  logic [16:0]          div_full;
  logic [23:0]          period;
  logic [23:0]          half;
  logic                 tx_dir;
  logic                 can_load;
  logic                 tx_tick;
  logic                 rx_tick;
  logic                 rx_half;
  logic                 fall;
  logic                 rise;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [8:0]           rd_word;

  // Base clock prescale from divider selects
  function automatic logic [6:0] sbs_prescale(input logic wide,
                                               input logic fast);
    logic [6:0] p;
    p = sbs_pkg::PRE_MID;
    if (wide && fast) begin
      p = sbs_pkg::PRE_FAST;
    end else if (!wide && !fast) begin
      p = sbs_pkg::PRE_SLOW;
    end
    return p;
  endfunction

  // Register read mux
  function automatic logic [8:0] sbs_read(input sbs_state_s s,
                                          input logic [7:0] a);
    logic [8:0] d;
    d = 9'h000;
    case (a)
      sbs_pkg::OFF_BAUD_CONTROL: begin
        d[sbs_pkg::BC_IDLE_RX]  = (s.rx_state == sbs_pkg::RX_IDLE);
        d[sbs_pkg::BC_CLK_POL]  = s.clk_pol;
        d[sbs_pkg::BC_WIDE_DIV] = s.wide_div;
        d[sbs_pkg::BC_WAKE]     = s.wake_en;
        d[sbs_pkg::BC_AUTOBAUD] = s.autobaud;
      end
      sbs_pkg::OFF_RX_STATUS_CTL: begin
        d[sbs_pkg::RS_PORT_EN]  = s.port_en;
        d[sbs_pkg::RS_NINE_RX]  = s.nine_rx;
        d[sbs_pkg::RS_SINGLE]   = s.single_rx;
        d[sbs_pkg::RS_CONT]     = s.cont_rx;
        d[sbs_pkg::RS_FRAME]    = s.frame_err;
        d[sbs_pkg::RS_NINTH_RX] = s.ninth_rx;
      end
      sbs_pkg::OFF_DIVISOR_LOW:  d[7:0] = s.div_low;
      sbs_pkg::OFF_DIVISOR_HIGH: d[7:0] = s.div_high;
      sbs_pkg::OFF_TX_STATUS_CTL: begin
        d[sbs_pkg::TS_MASTER]   = s.master;
        d[sbs_pkg::TS_NINE_TX]  = s.nine_tx;
        d[sbs_pkg::TS_TX_EN]    = s.tx_en;
        d[sbs_pkg::TS_SYNC]     = s.sync_mode;
        d[sbs_pkg::TS_BREAK]    = s.break_req;
        d[sbs_pkg::TS_HIGH_SPD] = s.high_spd;
        d[sbs_pkg::TS_SR_EMPTY] = (s.tx_state == sbs_pkg::TX_IDLE);
        d[sbs_pkg::TS_NINTH_TX] = s.ninth_tx;
      end
      sbs_pkg::OFF_RX_DATA: d[7:0] = s.rx_data;
      sbs_pkg::OFF_FLAGS: begin
        d[sbs_pkg::FL_TX_EMPTY] = !s.tx_full;
        d[sbs_pkg::FL_RX_READY] = s.rx_ready;
      end
      sbs_pkg::OFF_TX_DATA: d = 9'h000;
      // Flag in bit 8 marks an undecoded address
      default: d = 9'h100;
    endcase
    return d;
  endfunction

  assign req      = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};
  assign pready_o = 1'b1;
  assign rd_word  = sbs_read(st, req.paddr);
  assign wr_acc   = req.psel && req.penable && req.pwrite;
  assign rd_acc   = req.psel && req.penable && !req.pwrite;

  // Bit time from divisor pair and prescale
  assign div_full = st.wide_div ? {1'b0, st.div_high, st.div_low}
                                : {9'h000, st.div_low};
  assign period   = 24'(div_full + 17'h00001)
                    * 24'(sbs_prescale(st.wide_div, st.high_spd));
  assign half     = period >> 1;
  assign tx_tick  = (st.tx_cnt == period - 24'h000001);
  assign rx_tick  = (st.rx_cnt == period - 24'h000001);
  assign rx_half  = (st.rx_cnt == half - 24'h000001);
  assign fall     = st.line_prev && !st.line_sync;
  assign rise     = !st.line_prev && st.line_sync;

  // Direction: transmit only with both receive enables clear
  assign tx_dir   = !st.single_rx && !st.cont_rx;
  // Load waits for an empty shift register
  assign can_load = st.tx_full && st.tx_en && st.port_en
                    && (st.tx_state == sbs_pkg::TX_IDLE)
                    && (!st.sync_mode || (st.master && tx_dir));

  always_comb begin
    next_st           = st;
    next_st.line_meta = data_pin_i;
    next_st.line_sync = st.line_meta;
    next_st.line_prev = st.line_sync;
    next_st.slverr    = 1'b0;

    // Transmitter
    next_st.tx_cnt = tx_tick ? 24'h000000 : st.tx_cnt + 24'h000001;
    case (st.tx_state)
      sbs_pkg::TX_IDLE: begin
        next_st.tx_cnt = 24'h000000;
        if (can_load) begin
          next_st.tx_full  = 1'b0;
          next_st.tx_brk   = st.break_req && !st.sync_mode;
          if (st.break_req && !st.sync_mode) begin
            next_st.tx_shift = 12'h000;
            next_st.tx_bits  = sbs_pkg::BREAK_BITS;
          end else begin
            next_st.tx_shift = {3'h0, st.tx_buf};
            next_st.tx_bits  = st.nine_tx ? sbs_pkg::NINE_BITS
                                          : sbs_pkg::BYTE_BITS;
          end
          // No start bit in synchronous mode
          next_st.tx_state = st.sync_mode ? sbs_pkg::TX_DATA
                                          : sbs_pkg::TX_START;
        end
      end
      sbs_pkg::TX_START: begin
        if (tx_tick) begin
          next_st.tx_state = sbs_pkg::TX_DATA;
        end
      end
      sbs_pkg::TX_DATA: begin
        if (tx_tick) begin
          next_st.tx_shift = st.tx_shift >> 1;
          next_st.tx_bits  = st.tx_bits - 4'h1;
          if (st.tx_bits == 4'h1) begin
            // One clock per bit, then stop
            next_st.tx_state = st.sync_mode ? sbs_pkg::TX_IDLE
                                            : sbs_pkg::TX_STOP;
          end
        end
      end
      sbs_pkg::TX_STOP: begin
        if (tx_tick) begin
          next_st.tx_state = sbs_pkg::TX_IDLE;
          if (st.tx_brk) begin
            next_st.break_req = 1'b0;
            next_st.tx_brk    = 1'b0;
          end
        end
      end
      default: next_st.tx_state = sbs_pkg::TX_IDLE;
    endcase
    // Transmit disable aborts a synchronous character
    if (st.sync_mode && (!st.tx_en || !st.port_en)) begin
      next_st.tx_state = sbs_pkg::TX_IDLE;
    end

    // Asynchronous receiver, idle while waking or synchronous
    next_st.rx_cnt = st.rx_cnt + 24'h000001;
    case (st.rx_state)
      sbs_pkg::RX_IDLE: begin
        next_st.rx_cnt = 24'h000000;
        if (fall && st.port_en && st.cont_rx && !st.sync_mode
            && !st.wake_en) begin
          next_st.rx_state = sbs_pkg::RX_START;
          next_st.rx_bits  = st.nine_rx ? sbs_pkg::NINE_BITS
                                        : sbs_pkg::BYTE_BITS;
        end
      end
      sbs_pkg::RX_START: begin
        if (rx_half) begin
          next_st.rx_cnt   = 24'h000000;
          next_st.rx_state = st.line_sync ? sbs_pkg::RX_IDLE
                                          : sbs_pkg::RX_DATA;
        end
      end
      sbs_pkg::RX_DATA: begin
        if (rx_tick) begin
          next_st.rx_cnt   = 24'h000000;
          next_st.rx_shift = {st.line_sync, st.rx_shift[8:1]};
          next_st.rx_bits  = st.rx_bits - 4'h1;
          if (st.rx_bits == 4'h1) begin
            next_st.rx_state = sbs_pkg::RX_STOP;
          end
        end
      end
      sbs_pkg::RX_STOP: begin
        if (rx_tick) begin
          next_st.rx_state  = sbs_pkg::RX_IDLE;
          // Low stop bit reports a framing error, whatever the data
          next_st.frame_err = !st.line_sync;
          next_st.rx_data   = st.nine_rx ? st.rx_shift[7:0]
                                         : st.rx_shift[8:1];
          next_st.ninth_rx  = st.nine_rx && st.rx_shift[8];
        end
      end
      default: next_st.rx_state = sbs_pkg::RX_IDLE;
    endcase
    if (!st.port_en || st.sync_mode) begin
      next_st.rx_state = sbs_pkg::RX_IDLE;
    end

    // Register access: read data latched in the setup phase, writes at the access edge
    if (req.psel && !req.penable) begin
      {next_st.slverr, next_st.rdata} = {1'b0, 23'h000000, rd_word};
      if (rd_word[8]) begin
        next_st.rdata  = 32'h00000000;
        next_st.slverr = 1'b1;
      end
    end else begin
      next_st.slverr = st.slverr && req.psel;
    end
    if (rd_acc && (req.paddr == sbs_pkg::OFF_RX_DATA)) begin
      next_st.rx_ready = 1'b0;
    end
    if (wr_acc) begin
      case (req.paddr)
        sbs_pkg::OFF_BAUD_CONTROL: begin
          next_st.clk_pol  = req.pwdata[sbs_pkg::BC_CLK_POL];
          next_st.wide_div = req.pwdata[sbs_pkg::BC_WIDE_DIV];
          next_st.wake_en  = req.pwdata[sbs_pkg::BC_WAKE];
          next_st.autobaud = req.pwdata[sbs_pkg::BC_AUTOBAUD];
        end
        sbs_pkg::OFF_RX_STATUS_CTL: begin
          next_st.port_en   = req.pwdata[sbs_pkg::RS_PORT_EN];
          next_st.nine_rx   = req.pwdata[sbs_pkg::RS_NINE_RX];
          next_st.single_rx = req.pwdata[sbs_pkg::RS_SINGLE];
          next_st.cont_rx   = req.pwdata[sbs_pkg::RS_CONT];
        end
        sbs_pkg::OFF_DIVISOR_LOW:  next_st.div_low  = req.pwdata[7:0];
        sbs_pkg::OFF_DIVISOR_HIGH: next_st.div_high = req.pwdata[7:0];
        sbs_pkg::OFF_TX_DATA: begin
          if (!st.tx_full) begin
            next_st.tx_buf  = {st.ninth_tx, req.pwdata[7:0]};
            next_st.tx_full = 1'b1;
          end
        end
        sbs_pkg::OFF_TX_STATUS_CTL: begin
          next_st.master    = req.pwdata[sbs_pkg::TS_MASTER];
          next_st.nine_tx   = req.pwdata[sbs_pkg::TS_NINE_TX];
          next_st.tx_en     = req.pwdata[sbs_pkg::TS_TX_EN];
          next_st.sync_mode = req.pwdata[sbs_pkg::TS_SYNC];
          next_st.break_req = req.pwdata[sbs_pkg::TS_BREAK];
          next_st.high_spd  = req.pwdata[sbs_pkg::TS_HIGH_SPD];
          next_st.ninth_tx  = req.pwdata[sbs_pkg::TS_NINTH_TX];
        end
        default: next_st.slverr = st.slverr;
      endcase
    end

    // Wake on edge: falling flags, rising ends the break
    if (st.wake_en && st.port_en && !st.sync_mode) begin
      if (rise) begin
        next_st.wake_en = 1'b0;
      end
    end
    // Hardware sets win over the read clear
    if ((st.wake_en && st.port_en && !st.sync_mode && fall)
        || ((st.rx_state == sbs_pkg::RX_STOP) && rx_tick)) begin
      next_st.rx_ready = 1'b1;
    end

    // Pin drivers from the next state
    next_st.pins = '{1'b1, 1'b0, 1'b1, 1'b0};
    if (next_st.port_en && next_st.sync_mode) begin
      // Master drives clock; data only when transmitting
      next_st.pins.clock_pin_oe = next_st.master;
      next_st.pins.data_pin_oe  = next_st.master && !next_st.single_rx
                                  && !next_st.cont_rx;
      next_st.pins.clock_pin    = next_st.clk_pol;
      // Data holds past the last bit
      next_st.pins.data_pin     = st.pins.data_pin;
      if (next_st.tx_state == sbs_pkg::TX_DATA) begin
        // Leading edge at bit start, trailing at mid-bit
        next_st.pins.clock_pin = (next_st.tx_cnt < half)
                                 ? !next_st.clk_pol : next_st.clk_pol;
        next_st.pins.data_pin  = next_st.tx_shift[0];
      end
    end else if (next_st.port_en) begin
      next_st.pins.clock_pin_oe = next_st.tx_en;
      case (next_st.tx_state)
        sbs_pkg::TX_START: next_st.pins.clock_pin = 1'b0;
        sbs_pkg::TX_DATA:  next_st.pins.clock_pin = next_st.tx_shift[0];
        default:           next_st.pins.clock_pin = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st          <= '0;
      st.tx_state <= sbs_pkg::TX_IDLE;
      st.rx_state <= sbs_pkg::RX_IDLE;
      st.rx_data  <= sbs_pkg::RESET_BYTE;
      st.pins     <= '{1'b1, 1'b0, 1'b1, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o       = st.rdata;
  assign pslverr_o      = st.slverr;
  assign clock_pin_o    = st.pins.clock_pin;
  assign clock_pin_oe_o = st.pins.clock_pin_oe;
  assign data_pin_o     = st.pins.data_pin;
  assign data_pin_oe_o  = st.pins.data_pin_oe;

endmodule

// [src/sbs_pkg.sv]
// Package with register map, field positions and carriers of the serial block
package sbs_pkg;
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFF_BAUD_CONTROL  = 8'h00;
  localparam logic [7:0]  OFF_RX_STATUS_CTL = 8'h04;
  localparam logic [7:0]  OFF_DIVISOR_LOW   = 8'h08;
  localparam logic [7:0]  OFF_DIVISOR_HIGH  = 8'h0C;
  localparam logic [7:0]  OFF_TX_DATA       = 8'h10;
  localparam logic [7:0]  OFF_TX_STATUS_CTL = 8'h14;
  localparam logic [7:0]  OFF_RX_DATA       = 8'h18;
  localparam logic [7:0]  OFF_FLAGS         = 8'h1C;
  // baud_control fields
  localparam int unsigned BC_IDLE_RX  = 6;
  localparam int unsigned BC_CLK_POL  = 4;
  localparam int unsigned BC_WIDE_DIV = 3;
  localparam int unsigned BC_WAKE     = 1;
  localparam int unsigned BC_AUTOBAUD = 0;
  // receive_status_control fields
  localparam int unsigned RS_PORT_EN  = 7;
  localparam int unsigned RS_NINE_RX  = 6;
  localparam int unsigned RS_SINGLE   = 5;
  localparam int unsigned RS_CONT     = 4;
  localparam int unsigned RS_FRAME    = 2;
  localparam int unsigned RS_NINTH_RX = 0;
  // transmit_status_control fields
  localparam int unsigned TS_MASTER   = 7;
  localparam int unsigned TS_NINE_TX  = 6;
  localparam int unsigned TS_TX_EN    = 5;
  localparam int unsigned TS_SYNC     = 4;
  localparam int unsigned TS_BREAK    = 3;
  localparam int unsigned TS_HIGH_SPD = 2;
  localparam int unsigned TS_SR_EMPTY = 1;
  localparam int unsigned TS_NINTH_TX = 0;
  // flags fields
  localparam int unsigned FL_TX_EMPTY = 0;
  localparam int unsigned FL_RX_READY = 1;
  // Frame sizes and divider prescales
  localparam logic [3:0]  BREAK_BITS  = 4'hC;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  NINE_BITS   = 4'h9;
  localparam logic [6:0]  PRE_SLOW    = 7'h40;
  localparam logic [6:0]  PRE_MID     = 7'h10;
  localparam logic [6:0]  PRE_FAST    = 7'h04;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } sbs_tx_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } sbs_rx_e;

  typedef struct packed {
    logic clock_pin;
    logic clock_pin_oe;
    logic data_pin;
    logic data_pin_oe;
  } sbs_pins_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sbs_apb_req_s;
endpackage

// [testbench/sbs_serial_chk.sv]
// Checker on the ports of the serial block
`timescale 1ns/1ps
module sbs_serial_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        data_pin_i,
  input wire logic        data_pin_o,
  input wire logic        data_pin_oe_o,
  input wire logic        clock_pin_o,
  input wire logic        clock_pin_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_access_ready: assert property (psel_i && penable_i |-> pready_o)
    else $error("access without ready");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i > 8'h1C
    |-> pslverr_o) else $error("unmapped access without error");
  a_mapped_ok: assert property (psel_i && penable_i && paddr_i <= 8'h1C
    && paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("mapped access erred");
  a_txdata_hidden: assert property (psel_i && penable_i && !pwrite_i
    && paddr_i == sbs_pkg::OFF_TX_DATA |-> prdata_o == 32'h0)
    else $error("transmit data readable");
  a_drive_pair: assert property (data_pin_oe_o |-> clock_pin_oe_o)
    else $error("data driven without clock driver");
  a_clock_hold: assert property (data_pin_oe_o && $changed(clock_pin_o)
    |=> $stable(clock_pin_o)) else $error("clock half period too short");
  a_data_leading: assert property (data_pin_oe_o && $past(data_pin_oe_o)
    && $changed(data_pin_o) |-> $changed(clock_pin_o))
    else $error("data changed off the leading edge");
  a_reset_quiet: assert property ($rose(resetn_i) |-> clock_pin_o
    && !clock_pin_oe_o && !data_pin_oe_o) else $error("pins active after reset");
endmodule
bind sbs_serial sbs_serial_chk u_chk (.clk_i, .resetn_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
  .data_pin_i, .data_pin_o, .data_pin_oe_o, .clock_pin_o, .clock_pin_oe_o);

// [testbench/sbs_link_node.sv]
// Link partner: async line receiver, sync slave and line driver
`timescale 1ns/1ps
module sbs_link_node (
  input  wire logic clk_i,
  input  wire logic clock_pin_o,
  input  wire logic data_pin_o,
  input  wire logic data_pin_oe_o,
  input  wire logic sync_m,
  input  wire logic pol,
  input  wire logic [31:0] nbits,
  input  wire logic [31:0] bit_clks,
  output wire logic data_pin_i
);
  logic        drv = 1'h1;
  logic        last_ck = 1'h0;
  logic [15:0] v;
  logic [15:0] sh;
  int          cnt = 0;
  int          edges = 0;
  int          q[$];
  // Line pulled up when released; one talker at a time
  assign data_pin_i = data_pin_oe_o ? data_pin_o : drv;
  // Async frame sampled mid bit: start, data LSB first, stop
  always begin
    @(negedge clock_pin_o iff !sync_m);
    v = 16'h0;
    repeat (bit_clks / 2) @(posedge clk_i);
    if (!sync_m) begin
      for (int i = 0; i < nbits + 2; i++) begin
        v[i] = clock_pin_o;
        if (i < nbits + 1) repeat (bit_clks) @(posedge clk_i);
      end
      q.push_back(int'(v));
    end
  end
  // Sync slave: data taken at the edge into idle level
  always @(posedge clk_i) begin
    last_ck <= clock_pin_o;
    if (sync_m && clock_pin_o !== last_ck && clock_pin_o === pol) begin
      if (cnt == 0) sh = 16'h0;
      sh[cnt] = data_pin_o;
      edges++;
      cnt++;
      if (cnt == nbits) begin
        q.push_back(int'(sh));
        cnt = 0;
      end
    end
  end
  // Drive n bits LSB first, then one bit time high
  task automatic line_send(input logic [15:0] b, input int n);
    for (int i = 0; i <= n; i++) begin
      drv <= (i < n) ? b[i] : 1'h1;
      repeat (bit_clks) @(posedge clk_i);
    end
  endtask
endmodule

// [testbench/tb_serial_break_and_sync_master_tx.sv]
// Self-checking bench of the serial block
`timescale 1ns/1ps
module tb_serial_break_and_sync_master_tx;
  logic        clk_i = 1'h0, resetn_i = 1'h0, psel_i = 1'h0;
  logic        penable_i = 1'h0, pwrite_i = 1'h0, sync_m = 1'h0, pol = 1'h0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, d, ts;
  logic        pready_o, pslverr_o, data_pin_o, data_pin_oe_o, er;
  logic        clock_pin_o, clock_pin_oe_o;
  wire logic   data_pin_i;
  // Divisor 1 with both fast selects: (1+1)*4 clocks a bit
  int          nbits = 12, bit_clks = 8, n_errors = 0, compares = 0;
  int          exp_q[$];
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  sbs_serial uut (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .data_pin_i,
    .data_pin_o, .data_pin_oe_o, .clock_pin_o, .clock_pin_oe_o);
  sbs_link_node node (.clk_i, .clock_pin_o, .data_pin_o, .data_pin_oe_o,
    .sync_m, .pol, .nbits, .bit_clks, .data_pin_i);
  task automatic chk(input string what, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'h1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(what, rd, e);
  endtask
  task automatic wait_tx_empty();
    for (int n = 0; n < 200; n++) begin
      apb(1'h0, sbs_pkg::OFF_FLAGS, 32'h0);
      if (rd[sbs_pkg::FL_TX_EMPTY] === 1'h1) break;
    end
  endtask
  task automatic wait_frames(input int k);
    for (int n = 0; n < 2000 && node.q.size() < k; n++) @(posedge clk_i);
  endtask
  task automatic cmp_frames();
    while (exp_q.size() > 0)
      chk("frame", node.q.size() > 0 ? node.q.pop_front() : -1,
          exp_q.pop_front());
    node.q.delete();
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
  initial begin
    d = $urandom(32'hABA45C8B);
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++)
      rc("reset", 8'(i * 4), (i == 0) ? 32'h40 : (i == 5) ? 32'h2
         : (i == 7) ? 32'h1 : 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    // Break, then async byte queued behind it
    apb(1'h1, sbs_pkg::OFF_BAUD_CONTROL, 32'h08);
    apb(1'h1, sbs_pkg::OFF_DIVISOR_LOW, 32'h01);
    apb(1'h1, sbs_pkg::OFF_RX_STATUS_CTL, 32'h80);
    apb(1'h1, sbs_pkg::OFF_TX_STATUS_CTL, 32'h2C);
    apb(1'h1, sbs_pkg::OFF_TX_DATA, 32'hA7);
    rc("busy", sbs_pkg::OFF_TX_STATUS_CTL, 32'h2C);
    wait_tx_empty();
    apb(1'h1, sbs_pkg::OFF_TX_DATA, 32'h55);
    exp_q = '{32'h2000, 32'h2AA};
    wait_frames(1);
    nbits = 8;
    wait_frames(2);
    repeat (bit_clks) @(posedge clk_i);
    rc("tx_status", sbs_pkg::OFF_TX_STATUS_CTL, 32'h26);
    cmp_frames();
    // Break received as framing error with zero data
    apb(1'h1, sbs_pkg::OFF_TX_STATUS_CTL, 32'h04);
    apb(1'h1, sbs_pkg::OFF_RX_STATUS_CTL, 32'h90);
    node.line_send(16'h0, 13);
    rc("rx_ready", sbs_pkg::OFF_FLAGS, 32'h3);
    rc("frame_err", sbs_pkg::OFF_RX_STATUS_CTL, 32'h94);
    rc("rx_data", sbs_pkg::OFF_RX_DATA, 32'h0);
    rc("rx_clear", sbs_pkg::OFF_FLAGS, 32'h1);
    // Wake on edge, then an ordinary byte
    apb(1'h1, sbs_pkg::OFF_BAUD_CONTROL, 32'h0B);
    node.line_send(16'h0, 13);
    rc("wake_flag", sbs_pkg::OFF_FLAGS, 32'h3);
    apb(1'h0, sbs_pkg::OFF_BAUD_CONTROL, 32'h0);
    chk("wake_clear", rd & 32'hBF, 32'h09);
    apb(1'h0, sbs_pkg::OFF_RX_DATA, 32'h0);
    d = $urandom & 32'hFF;
    node.line_send({7'h0, d[7:0], 1'h0}, 9);
    rc("byte_ready", sbs_pkg::OFF_FLAGS, 32'h3);
    rc("byte_data", sbs_pkg::OFF_RX_DATA, d);
    // Sync master: polarity low then high, 8 and 9 bits
    apb(1'h1, sbs_pkg::OFF_RX_STATUS_CTL, 32'h80);
    for (int k = 0; k < 4; k++) begin
      sync_m <= 1'h0;
      pol <= k[1];
      nbits = 8 + k % 2;
      apb(1'h1, sbs_pkg::OFF_BAUD_CONTROL, {27'h0, k[1], 4'h8});
      ts = 32'hB4 | ((k % 2) << 6) | ($urandom & 1);
      apb(1'h1, sbs_pkg::OFF_TX_STATUS_CTL, ts);
      sync_m <= 1'h1;
      @(posedge clk_i);
      chk("clk_drive", {31'h0, clock_pin_oe_o}, 32'h1);
      chk("data_drive", {31'h0, data_pin_oe_o}, 32'h1);
      node.edges = 0;
      node.cnt = 0;
      repeat (2) begin
        d = $urandom & 32'hFF;
        exp_q.push_back(int'({23'h0, ts[0], d[7:0]} & ((1 << nbits) - 1)));
        apb(1'h1, sbs_pkg::OFF_TX_DATA, d);
        wait_tx_empty();
      end
      wait_frames(2);
      repeat (bit_clks) @(posedge clk_i);
      chk("clk_idle", {31'h0, clock_pin_o}, {31'h0, k[1]});
      chk("clk_count", node.edges, 2 * nbits);
      cmp_frames();
    end
    apb(1'h1, sbs_pkg::OFF_TX_DATA, 32'hFF);
    apb(1'h1, sbs_pkg::OFF_TX_STATUS_CTL, 32'h94);
    repeat (bit_clks) @(posedge clk_i);
    chk("clk_abort", {31'h0, clock_pin_o}, 32'h1);
    report_and_stop();
  end
endmodule
